// *** hdl/pllms_top.sv ***
// Purpose: decode pll tuning selects and output source selects from a 128-bit configuration word
// Assumes: AXI4-Lite slave on aclk; set-select pin is asynchronous
// Notes:   slew flags model the loop settling time; glitch flag warns of route changes
`include "pllms_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module pllms_top
(
    // clock and reset
    input  wire logic                              aclk,
    input  wire logic                              aresetn,
    // write address channel
    input  wire logic                              s_axi_awvalid,
    output var  logic                              s_axi_awready,
    input  wire logic [`PLLMS_ADDR_W-1:0]          s_axi_awaddr,
    input  wire logic [2:0]                        s_axi_awprot,
    // write data channel
    input  wire logic                              s_axi_wvalid,
    output var  logic                              s_axi_wready,
    input  wire logic [31:0]                       s_axi_wdata,
    input  wire logic [3:0]                        s_axi_wstrb,
    // write response channel
    output var  logic                              s_axi_bvalid,
    input  wire logic                              s_axi_bready,
    output var  logic [1:0]                        s_axi_bresp,
    // read address channel
    input  wire logic                              s_axi_arvalid,
    output var  logic                              s_axi_arready,
    input  wire logic [`PLLMS_ADDR_W-1:0]          s_axi_araddr,
    input  wire logic [2:0]                        s_axi_arprot,
    // read data channel
    output var  logic                              s_axi_rvalid,
    input  wire logic                              s_axi_rready,
    output var  logic [31:0]                       s_axi_rdata,
    output var  logic [1:0]                        s_axi_rresp,
    // set-select pin
    input  wire logic                              set_select_pin,
    // applied selections
    output var  pllms_pkg::pllms_tune_t            tune,
    output var  pllms_pkg::pllms_route_t           route,
    output var  logic [2:0]                        slewing,
    output var  logic                              route_glitch
);

    // ----------------------------------------------------------------
    // constants
    // ----------------------------------------------------------------
    localparam logic [`PLLMS_CNT_W-1:0] TC_SHORT = `PLLMS_CNT_W'(`PLLMS_TC_SHORT_CYC);
    localparam logic [`PLLMS_CNT_W-1:0] TC_LONG  = `PLLMS_CNT_W'(`PLLMS_TC_LONG_CYC);

    localparam pllms_pkg::pllms_state_t ST_RST = '{
        cfg:     `PLLMS_CFG_RST,
        wst:     pllms_pkg::PLLMS_WR_IDLE,
        rst:     pllms_pkg::PLLMS_RD_IDLE,
        awready: 1'b1,
        wready:  1'b1,
        arready: 1'b1,
        route:   '{pllms_pkg::PLLMS_SRC_REF, pllms_pkg::PLLMS_SRC_REF,
                   pllms_pkg::PLLMS_SRC_REF, pllms_pkg::PLLMS_SRC_REF},
        default: '0
    };

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    pllms_pkg::pllms_state_t q;
    pllms_pkg::pllms_state_t d;
    logic                    pin_level;

    pllms_sync u_sync
    (
        .aclk    (aclk),
        .aresetn (aresetn),
        .pin     (set_select_pin),
        .level   (pin_level)
    );

    // ----------------------------------------------------------------
    // read data mux: {resp, data}
    // ----------------------------------------------------------------
    function automatic logic [33:0] rd_word
    (
        input logic [`PLLMS_ADDR_W-1:0] addr,
        input pllms_pkg::pllms_state_t  s
    );
        logic [31:0] w;
        logic [1:0]  r;
        w = 32'h0;
        r = `PLLMS_RESP_OKAY;
        case (addr)
            `PLLMS_OFS_CFG0: w = s.cfg[31:0];
            `PLLMS_OFS_CFG1: w = s.cfg[63:32];
            `PLLMS_OFS_CFG2: w = s.cfg[95:64];
            `PLLMS_OFS_CFG3: w = s.cfg[127:96];
            `PLLMS_OFS_STATUS:
            begin
                w[`PLLMS_STAT_SEL]                     = s.sel;
                w[`PLLMS_STAT_SLEW +: 3]               = s.slewing;
                w[`PLLMS_STAT_GLITCH]                  = s.glitch;
            end
            `PLLMS_OFS_APPLIED:
            begin
                w[2:0]   = s.tune.filter_const_sel;
                w[6:4]   = s.tune.pump_current_sel;
                w[9:8]   = s.route.out_a;
                w[11:10] = s.route.out_b;
                w[13:12] = s.route.out_c;
                w[15:14] = s.route.out_d;
            end
            default: r = `PLLMS_RESP_SLVERR;
        endcase
        return {r, w};
    endfunction : rd_word

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb
    begin
        logic                           aw_fire;
        logic                           w_fire;
        logic                           have_aw;
        logic                           have_w;
        logic [`PLLMS_ADDR_W-1:0]       waddr;
        logic [31:0]                    wdata;
        logic [3:0]                     wstrb;
        logic [33:0]                    rword;
        logic                           filter_const_sel_c_first;
        logic                           filter_const_sel_c_second;
        logic                           pump_current_sel_c_first;
        logic                           pump_current_sel_c_second;
        logic [1:0]                     source_sel_out_c_first;
        logic [1:0]                     source_sel_out_c_second;
        logic [1:0]                     source_sel_out_d_first;
        logic [1:0]                     source_sel_out_d_second;
        pllms_pkg::pllms_tune_t         nt;
        pllms_pkg::pllms_route_t        nr;

        d       = q;
        nt      = q.tune;
        nr      = q.route;
        filter_const_sel_c_first  = q.cfg[`PLLMS_BIT_FILT_C1];
        filter_const_sel_c_second = q.cfg[`PLLMS_BIT_FILT_C2];
        pump_current_sel_c_first  = q.cfg[`PLLMS_BIT_PUMP_C1];
        pump_current_sel_c_second = q.cfg[`PLLMS_BIT_PUMP_C2];
        source_sel_out_c_first    = q.cfg[`PLLMS_BIT_SRC_C1 +: 2];
        source_sel_out_c_second   = q.cfg[`PLLMS_BIT_SRC_C2 +: 2];
        source_sel_out_d_first    = q.cfg[`PLLMS_BIT_SRC_D1 +: 2];
        source_sel_out_d_second   = q.cfg[`PLLMS_BIT_SRC_D2 +: 2];
        aw_fire = s_axi_awvalid && q.awready;
        w_fire  = s_axi_wvalid && q.wready;
        have_aw = q.aw_have || aw_fire;
        have_w  = q.w_have || w_fire;
        waddr   = q.aw_have ? q.aw_addr : s_axi_awaddr;
        wdata   = q.w_have ? q.w_data : s_axi_wdata;
        wstrb   = q.w_have ? q.w_strb : s_axi_wstrb;
        rword   = rd_word(s_axi_araddr, q);

        // write channels, address and data taken in either order
        case (q.wst)
            pllms_pkg::PLLMS_WR_IDLE:
            begin
                if (aw_fire)
                begin
                    d.aw_have = 1'b1;
                    d.aw_addr = s_axi_awaddr;
                end
                if (w_fire)
                begin
                    d.w_have = 1'b1;
                    d.w_data = s_axi_wdata;
                    d.w_strb = s_axi_wstrb;
                end
                if (have_aw && have_w)
                begin
                    d.aw_have = 1'b0;
                    d.w_have  = 1'b0;
                    d.bvalid  = 1'b1;
                    d.bresp   = `PLLMS_RESP_OKAY;
                    d.wst     = pllms_pkg::PLLMS_WR_RESP;
                    case (waddr)
                        `PLLMS_OFS_CFG0, `PLLMS_OFS_CFG1, `PLLMS_OFS_CFG2, `PLLMS_OFS_CFG3:
                        begin
                            for (int b = 0; b < 4; b++)
                            begin
                                if (wstrb[b])
                                begin
                                    d.cfg[{waddr[3:2], 5'h0} + 7'(b * 8) +: 8] = wdata[b*8 +: 8];
                                end
                            end
                        end
                        `PLLMS_OFS_STATUS:
                        begin
                            if (wstrb[0] && wdata[`PLLMS_STAT_GLITCH])
                            begin
                                d.glitch = 1'b0;
                            end
                        end
                        `PLLMS_OFS_APPLIED: d.bresp = `PLLMS_RESP_OKAY;
                        default:            d.bresp = `PLLMS_RESP_SLVERR;
                    endcase
                end
            end
            pllms_pkg::PLLMS_WR_RESP:
            begin
                if (s_axi_bready)
                begin
                    d.bvalid = 1'b0;
                    d.wst    = pllms_pkg::PLLMS_WR_IDLE;
                end
            end
            default:
            begin
                d.wst     = pllms_pkg::PLLMS_WR_IDLE;
                d.bvalid  = 1'b0;
                d.aw_have = 1'b0;
                d.w_have  = 1'b0;
            end
        endcase
        d.awready = (d.wst == pllms_pkg::PLLMS_WR_IDLE) && !d.aw_have;
        d.wready  = (d.wst == pllms_pkg::PLLMS_WR_IDLE) && !d.w_have;

        // read channels
        case (q.rst)
            pllms_pkg::PLLMS_RD_IDLE:
            begin
                if (s_axi_arvalid)
                begin
                    d.arready = 1'b0;
                    d.rvalid  = 1'b1;
                    d.rresp   = rword[33:32];
                    d.rdata   = rword[31:0];
                    d.rst     = pllms_pkg::PLLMS_RD_DATA;
                end
            end
            pllms_pkg::PLLMS_RD_DATA:
            begin
                if (s_axi_rready)
                begin
                    d.rvalid  = 1'b0;
                    d.arready = 1'b1;
                    d.rst     = pllms_pkg::PLLMS_RD_IDLE;
                end
            end
            default:
            begin
                d.rvalid  = 1'b0;
                d.arready = 1'b1;
                d.rst     = pllms_pkg::PLLMS_RD_IDLE;
            end
        endcase

        // pll tuning decode
        d.sel                     = pin_level;
        nt.filter_const_sel[0]    = q.cfg[`PLLMS_BIT_FILT_A];
        nt.filter_const_sel[1]    = q.cfg[`PLLMS_BIT_FILT_B];
        nt.pump_current_sel[0]    = q.cfg[`PLLMS_BIT_PUMP_A];
        nt.pump_current_sel[1]    = q.cfg[`PLLMS_BIT_PUMP_B];
        nt.filter_const_sel[2]    = q.sel ? filter_const_sel_c_second : filter_const_sel_c_first;
        nt.pump_current_sel[2]    = q.sel ? pump_current_sel_c_second
                                          : pump_current_sel_c_first;

        // output source decode
        nr.out_a = pllms_pkg::pllms_src_t'(q.cfg[`PLLMS_BIT_SRC_A +: 2]);
        nr.out_b = pllms_pkg::pllms_src_t'(q.cfg[`PLLMS_BIT_SRC_B +: 2]);
        nr.out_c = pllms_pkg::pllms_src_t'(q.sel ? source_sel_out_c_second
                                                 : source_sel_out_c_first);
        nr.out_d = pllms_pkg::pllms_src_t'(q.sel ? source_sel_out_d_second
                                                 : source_sel_out_d_first);

        // a changed tuning restarts that loop's settling window
        for (int i = 0; i < 3; i++)
        begin
            if ((nt.filter_const_sel[i] != q.tune.filter_const_sel[i]) ||
                (nt.pump_current_sel[i] != q.tune.pump_current_sel[i]))
            begin
                d.slew_cnt[i] = nt.filter_const_sel[i] ? TC_LONG : TC_SHORT;
            end
            else if (q.slew_cnt[i] != '0)
                d.slew_cnt[i] = q.slew_cnt[i] - `PLLMS_CNT_W'(1);
            d.slewing[i] = (d.slew_cnt[i] != '0);
        end

        // sticky warning; a new change beats a clear in the same cycle
        if (nr != q.route)
        begin
            d.glitch = 1'b1;
        end

        d.tune  = nt;
        d.route = nr;
    end

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            q <= ST_RST;
        else
            q <= d;
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign s_axi_awready = q.awready;
    assign s_axi_wready  = q.wready;
    assign s_axi_bvalid  = q.bvalid;
    assign s_axi_bresp   = q.bresp;
    assign s_axi_arready = q.arready;
    assign s_axi_rvalid  = q.rvalid;
    assign s_axi_rdata   = q.rdata;
    assign s_axi_rresp   = q.rresp;
    assign tune          = q.tune;
    assign route         = q.route;
    assign slewing       = q.slewing;
    assign route_glitch  = q.glitch;

endmodule : pllms_top

`default_nettype wire

// *** pkg/pllms_consts.svh ***
// Purpose: offsets, field positions, reset values and timing counts of the pll tuning and route decoder
// Assumes: 128-bit configuration word held as four 32-bit words
// Notes:   definitions only
`ifndef PLLMS_CONSTS_SVH
`define PLLMS_CONSTS_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define PLLMS_ADDR_W           8
`define PLLMS_OFS_CFG0         8'h00
`define PLLMS_OFS_CFG1         8'h04
`define PLLMS_OFS_CFG2         8'h08
`define PLLMS_OFS_CFG3         8'h0C
`define PLLMS_OFS_STATUS       8'h10
`define PLLMS_OFS_APPLIED      8'h14

// ----------------------------------------------------------------
// configuration word bit positions
// ----------------------------------------------------------------
`define PLLMS_BIT_PUMP_A       19
`define PLLMS_BIT_FILT_A       20
`define PLLMS_BIT_SRC_A        22
`define PLLMS_BIT_PUMP_B       43
`define PLLMS_BIT_FILT_B       44
`define PLLMS_BIT_SRC_B        46
`define PLLMS_BIT_PUMP_C1      67
`define PLLMS_BIT_FILT_C1      68
`define PLLMS_BIT_SRC_C1       70
`define PLLMS_BIT_PUMP_C2      91
`define PLLMS_BIT_FILT_C2      92
`define PLLMS_BIT_SRC_D1       94
`define PLLMS_BIT_SRC_C2       124
`define PLLMS_BIT_SRC_D2       126

// ----------------------------------------------------------------
// status fields
// ----------------------------------------------------------------
`define PLLMS_STAT_SEL         0
`define PLLMS_STAT_SLEW        1
`define PLLMS_STAT_GLITCH      4

// ----------------------------------------------------------------
// reset values and bus answers
// ----------------------------------------------------------------
`define PLLMS_CFG_RST          128'h0
`define PLLMS_RESP_OKAY        2'h0
`define PLLMS_RESP_SLVERR      2'h2

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define PLLMS_CLK_NS           50
`define PLLMS_TC_SHORT_NS      7000
`define PLLMS_TC_LONG_NS       20000
`define PLLMS_CNT_W            9
`define PLLMS_TC_SHORT_CYC     ((`PLLMS_TC_SHORT_NS + `PLLMS_CLK_NS - 1) / `PLLMS_CLK_NS)
`define PLLMS_TC_LONG_CYC      ((`PLLMS_TC_LONG_NS + `PLLMS_CLK_NS - 1) / `PLLMS_CLK_NS)

`endif

// *** pkg/pllms_pkg.sv ***
// Purpose: types of the pll tuning and route decoder
// Assumes: constants come from pllms_consts.svh
// Notes:   state structs hold every flip-flop of a module
`include "pllms_consts.svh"
`default_nettype none

package pllms_pkg;

    // ----------------------------------------------------------------
    // modes and states
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        PLLMS_SRC_REF = 2'h0,
        PLLMS_SRC_A   = 2'h1,
        PLLMS_SRC_B   = 2'h2,
        PLLMS_SRC_C   = 2'h3
    } pllms_src_t;

    typedef enum logic [1:0] {
        PLLMS_WR_IDLE = 2'h1,
        PLLMS_WR_RESP = 2'h2
    } pllms_wr_state_t;

    typedef enum logic [1:0] {
        PLLMS_RD_IDLE = 2'h1,
        PLLMS_RD_DATA = 2'h2
    } pllms_rd_state_t;

    // ----------------------------------------------------------------
    // carriers; index 0 is pll a, 1 pll b, 2 pll c
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [2:0] filter_const_sel;
        logic [2:0] pump_current_sel;
    } pllms_tune_t;

    typedef struct packed {
        pllms_src_t out_d;
        pllms_src_t out_c;
        pllms_src_t out_b;
        pllms_src_t out_a;
    } pllms_route_t;

    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic stable;
    } pllms_sync_state_t;

    typedef struct packed {
        logic [127:0]                   cfg;
        pllms_wr_state_t                wst;
        pllms_rd_state_t                rst;
        logic                           awready;
        logic                           wready;
        logic                           bvalid;
        logic [1:0]                     bresp;
        logic                           arready;
        logic                           rvalid;
        logic [1:0]                     rresp;
        logic [31:0]                    rdata;
        logic                           aw_have;
        logic [`PLLMS_ADDR_W-1:0]       aw_addr;
        logic                           w_have;
        logic [31:0]                    w_data;
        logic [3:0]                     w_strb;
        logic                           sel;
        pllms_tune_t                    tune;
        pllms_route_t                   route;
        logic [2:0][`PLLMS_CNT_W-1:0]   slew_cnt;
        logic [2:0]                     slewing;
        logic                           glitch;
    } pllms_state_t;

endpackage : pllms_pkg

`default_nettype wire

// *** hdl/pllms_sync.sv ***
// Purpose: three-stage synchroniser with agreement filter for a pin input
// Assumes: pin is asynchronous to aclk
// Notes:   output follows once the second and third stages agree
`include "pllms_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module pllms_sync
(
    // clock and reset
    input  wire logic  aclk,
    input  wire logic  aresetn,
    // pin and filtered level
    input  wire logic  pin,
    output var  logic  level
);

    pllms_pkg::pllms_sync_state_t q;
    pllms_pkg::pllms_sync_state_t d;

    always_comb
    begin
        d = q;
        d.s1 = pin;
        d.s2 = q.s1;
        d.s3 = q.s2;
        if (q.s2 == q.s3)
        begin
            d.stable = q.s3;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            q <= '0;
        end
        else
        begin
            q <= d;
        end
    end

    assign level = q.stable;

endmodule : pllms_sync

`default_nettype wire

// *** tb/pllms_top_asserts.sv ***
// Purpose: port assertions for pllms_top
// Assumes: one clock domain, synchronous active-low reset
// Notes:   bound from the bench top file
`timescale 1ns/1ps
`default_nettype none
module pllms_top_asserts
(
    // clock and reset
    input wire logic                    aclk,
    input wire logic                    aresetn,
    // bus answers
    input wire logic                    s_axi_bvalid,
    input wire logic                    s_axi_bready,
    input wire logic [1:0]              s_axi_bresp,
    input wire logic                    s_axi_arvalid,
    input wire logic                    s_axi_arready,
    input wire logic                    s_axi_rvalid,
    input wire logic                    s_axi_rready,
    input wire logic [31:0]             s_axi_rdata,
    // applied selections
    input wire pllms_pkg::pllms_tune_t  tune,
    input wire pllms_pkg::pllms_route_t route,
    input wire logic [2:0]              slewing,
    input wire logic                    route_glitch
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    property p_b_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp); endproperty
    a_b_hold: assert property (p_b_hold) else $error("write answer dropped early");
    property p_r_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
    a_r_hold: assert property (p_r_hold) else $error("read answer dropped early");
    property p_r_lat; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
    a_r_lat: assert property (p_r_lat) else $error("read answer late");
    property p_tune_ab; $changed({tune.filter_const_sel[1:0], tune.pump_current_sel[1:0]}) |-> $past(s_axi_bvalid); endproperty
    a_tune_ab: assert property (p_tune_ab) else $error("pll a or b tuning moved without write");
    property p_route_ab; $changed({route.out_b, route.out_a}) |-> $past(s_axi_bvalid); endproperty
    a_route_ab: assert property (p_route_ab) else $error("route a or b moved without write");
    property p_slew_set; $changed(tune) |-> ((tune ^ $past(tune)) & ~{slewing, slewing}) == 6'h00; endproperty
    a_slew_set: assert property (p_slew_set) else $error("tuning change without slew flag");
    property p_slew_len; $rose(slewing[0]) |-> slewing[0] [*8]; endproperty
    a_slew_len: assert property (p_slew_len) else $error("slew window too short");
    property p_glitch; $changed(route) |-> route_glitch; endproperty
    a_glitch: assert property (p_glitch) else $error("route change not flagged");
endmodule : pllms_top_asserts
`default_nettype wire

// *** tb/tb_pllms_top.sv ***
// Purpose: self-checking bench for pllms_top
// Assumes: pin reaches outputs within 10 cycles
// Notes:   inputs change only by non-blocking assignment at the rising edge
`include "pllms_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module tb_pllms_top;
    logic                    aclk = 1'b0;
    logic                    aresetn = 1'b0;
    logic                    awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic                    pin = 1'b0;
    logic [7:0]              awaddr = 8'h00, araddr = 8'h00;
    logic [31:0]             wdata = 32'h0, rdata;
    logic                    awready, wready, bvalid, arready, rvalid, glitch;
    logic [1:0]              bresp, rresp, e;
    logic [2:0]              slewing;
    pllms_pkg::pllms_tune_t  tune;
    pllms_pkg::pllms_route_t route;
    int                      fails = 0, n_tests = 0;
    always #25 aclk = ~aclk;
    pllms_top dut_u (.aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_bresp(bresp), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_araddr(araddr),
        .s_axi_arprot(3'h0), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .set_select_pin(pin), .tune(tune), .route(route), .slewing(slewing),
        .route_glitch(glitch));
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            fails++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        @(posedge aclk);
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        awaddr <= a;
        wdata <= d;
        bready <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        bready <= 1'b0;
        chk("bresp", 32'(bresp), 32'(er));
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
        @(posedge aclk);
        arvalid <= 1'b1;
        araddr <= a;
        rready <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        rready <= 1'b0;
        chk("rdata", rdata, exp);
        chk("rresp", 32'(rresp), 32'(er));
    endtask : rd
    task automatic give_verdict;
        $display("mismatches %0d comparisons %0d", fails, n_tests);
        if (fails == 0 && n_tests > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : give_verdict
    initial
    begin
        repeat (20000) @(posedge aclk);
        fails++;
        give_verdict();
    end
    initial
    begin
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        chk("tune", 32'(tune), 32'h0);
        chk("route", 32'(route), 32'h0);
        rd(`PLLMS_OFS_APPLIED, 32'h0, `PLLMS_RESP_OKAY);
        for (int k = 0; k < 4; k++)
        begin
            e = 2'(k);
            wr(`PLLMS_OFS_CFG0, {8'h0, e, 1'b0, e[0], e[1], 19'h0}, `PLLMS_RESP_OKAY);
            wr(`PLLMS_OFS_CFG1, {16'h0, ~e, 1'b0, e[1], e[0], 11'h0}, `PLLMS_RESP_OKAY);
            wr(`PLLMS_OFS_CFG2, {e + 2'd1, 1'b0, ~e[0], e[1], 19'h0, ~e, 1'b0, e[1], ~e[0], 3'h0}, 2'h0);
            wr(`PLLMS_OFS_CFG3, {e + 2'd2, e + 2'd3, 28'h0}, `PLLMS_RESP_OKAY);
            repeat (10) @(posedge aclk);
            chk("tune", 32'(tune), 32'({e[1], e[1], e[0], ~e[0], e[0], e[1]}));
            chk("route", 32'(route), 32'({e + 2'd1, ~e, ~e, e}));
            pin <= 1'b1;
            repeat (10) @(posedge aclk);
            chk("tune", 32'(tune), 32'({~e[0], e[1], e[0], e[1], e[0], e[1]}));
            chk("route", 32'(route), 32'({e + 2'd2, e + 2'd3, ~e, e}));
            pin <= 1'b0;
            repeat (10) @(posedge aclk);
        end
        repeat (450) @(posedge aclk);
        wr(`PLLMS_OFS_CFG0, {8'h0, 2'b11, 2'b00, 1'b1, 19'h0}, `PLLMS_RESP_OKAY);
        repeat (150) @(posedge aclk);
        chk("slew short", 32'(slewing[0]), 32'h0);
        wr(`PLLMS_OFS_CFG0, {8'h0, 2'b11, 3'b011, 19'h0}, `PLLMS_RESP_OKAY);
        repeat (150) @(posedge aclk);
        chk("slew long", 32'(slewing[0]), 32'h1);
        chk("glitch", 32'(glitch), 32'h1);
        wr(`PLLMS_OFS_STATUS, 32'h10, `PLLMS_RESP_OKAY);
        rd(`PLLMS_OFS_STATUS, 32'h2, `PLLMS_RESP_OKAY);
        rd(`PLLMS_OFS_APPLIED, 32'h337, `PLLMS_RESP_OKAY);
        rd(8'h20, 32'h0, `PLLMS_RESP_SLVERR);
        wr(8'h20, 32'hFFFF_FFFF, `PLLMS_RESP_SLVERR);
        rd(`PLLMS_OFS_CFG0, 32'h00D8_0000, `PLLMS_RESP_OKAY);
        give_verdict();
    end
endmodule : tb_pllms_top
bind pllms_top pllms_top_asserts u_chk (.aclk, .aresetn, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .tune, .route, .slewing,
    .route_glitch);
`default_nettype wire
